/* File: rtl/tsc_pkg.sv */
// Package with register map, field positions, reset values and modes of the timer trigger controller
// Functional notes
// [RULE1] Prescaler clock: master, input edge, internal trigger
// [RULE2] Mode 000: software control bits, update-generate self-clears
// [RULE3] Internal clock runs once counter enable set
// [RULE4] Mode 111 counts selected input edges
// [RULE5] Each external edge: count, flag, interrupt request
// [RULE6] Trigger sources: input one, two, internal
// [RULE7] Mode 110: trigger rising edge starts counter
// [RULE8] Standard trigger counts master clock, sets flag
// [RULE9] Trigger input resynchronised, fixed latency
// [RULE10] Mode 100: trigger reinitialises counter and prescaler
// [RULE11] Reset trigger makes update event if source low
// [RULE12] Reset trigger sets flag, requests interrupt
// [RULE13] Mode 101: count only while trigger active
// [RULE14] Gated mode halted while enable is zero
// [RULE15] Gated mode flags both start and stop
// [RULE16] Master drives trigger output for slave timers
// [RULE17] Compare write high first, shadow waits low
// [RULE18] Output mode reads return preload contents
// [RULE19] Input mode read-only, capture via shadow
// [RULE20] Capture preload frozen during two-byte read
// [RULE21] High byte read latches low byte
// [RULE22] Started counter runs until software stops
package tsc_pkg;
    localparam logic [7:0] TSC_CTRL_OFS = 8'h00;
    localparam logic [7:0] TSC_SMODE_OFS = 8'h04;
    localparam logic [7:0] TSC_IEN_OFS = 8'h08;
    localparam logic [7:0] TSC_STAT_OFS = 8'h0c;
    localparam logic [7:0] TSC_EVGEN_OFS = 8'h10;
    localparam logic [7:0] TSC_CNTH_OFS = 8'h14;
    localparam logic [7:0] TSC_CNTL_OFS = 8'h18;
    localparam logic [7:0] TSC_PSC_OFS = 8'h1c;
    localparam logic [7:0] TSC_ARRH_OFS = 8'h20;
    localparam logic [7:0] TSC_ARRL_OFS = 8'h24;
    localparam logic [7:0] TSC_CCH_OFS = 8'h28;
    localparam logic [7:0] TSC_CCL_OFS = 8'h2c;
    localparam logic [7:0] TSC_CCMODE_OFS = 8'h30;
    // Control register fields
    localparam int TSC_CEN_BIT = 0;
    localparam int TSC_DIR_BIT = 1;
    localparam int TSC_URS_BIT = 2;
    localparam int TSC_ARPE_BIT = 3;
    // Slave mode register fields
    localparam int TSC_SMS_LSB = 0;
    localparam int TSC_TSEL_LSB = 4;
    localparam int TSC_EPOL_BIT = 6;
    localparam int TSC_MMS_BIT = 7;
    // Status, enable, event bits
    localparam int TSC_TIF_BIT = 0;
    localparam int TSC_UIF_BIT = 1;
    localparam int TSC_TIE_BIT = 0;
    localparam int TSC_UG_BIT = 0;
    localparam int TSC_CCIN_BIT = 0;
    localparam logic [15:0] TSC_ARR_RST = 16'hffff;
    localparam logic [15:0] TSC_ZERO16 = 16'h0000;
    localparam logic [3:0] TSC_PSC_RST = 4'h0;
    localparam logic [1:0] TSC_TSEL_IN1 = 2'h0;
    localparam logic [1:0] TSC_TSEL_IN2 = 2'h1;
    typedef enum logic [2:0] {
        TSC_SMS_OFF = 3'b000,
        TSC_SMS_RESET = 3'b100,
        TSC_SMS_GATED = 3'b101,
        TSC_SMS_TRIG = 3'b110,
        TSC_SMS_EXT1 = 3'b111
    } tsc_sms_t;
endpackage : tsc_pkg

/* File: rtl/tsc_top.sv */
// Clock/trigger controller of the general timer with APB register access
`timescale 1ns/1ps
module tsc_top
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic input_one,
    input wire logic input_two,
    input wire logic internal_trigger_input,
    output logic trigger_output,
    output logic trigger_irq,
    output logic compare_match
);
    logic [2:0] sync1_r, sync2_r, sms_r;
    logic [1:0] tsel_r;
    logic [3:0] psc_pre_r, psc_sh_r;
    logic [7:0] cnt_lat_r, wb;
    logic [15:0] cnt_r, psc_cnt_r, arr_pre_r, arr_sh_r, cc_pre_r, cc_sh_r, psc_lim;
    logic [31:0] prdata_r;
    logic trig_d_r, in1_d_r, pready_r, pslverr_r, cen_r, dir_r, urs_r, arpe_r, epol_r, mms_r, tie_r, tif_r;
    logic uif_r, ug_r, arr_lock_r, cc_lock_r, cc_in_r, cap_pend_r, cc_freeze_r, cnt_lat_vld_r, trigger_output_r, irq_r;
    logic match_r, trig, trig_rise, trig_fall, ext_edge, in1_rise, acc, wr, rd, running, psc_clk, cnt_tick;
    logic ovf, rst_trig, update_event, uev_flag, tif_set;

    assign acc = psel & penable & pready_r;
    assign wr = acc & pwrite;
    assign rd = acc & ~pwrite;
    assign wb = pwdata[7:0];

    // Every trigger source takes the same two stages, so latency is mode independent
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            sync1_r <= 3'h0;
            sync2_r <= 3'h0;
            trig_d_r <= 1'b0;
            in1_d_r <= 1'b0;
        end
        else
        begin
            sync1_r <= {internal_trigger_input, input_two, input_one}; // [RULE9]
            sync2_r <= sync1_r;
            trig_d_r <= trig;
            in1_d_r <= sync2_r[0];
        end
    end

    // Trigger source mux reads only second stage
    always_comb
    begin
        if (tsel_r == tsc_pkg::TSC_TSEL_IN1)
            trig = sync2_r[0]; // [RULE6]
        else if (tsel_r == tsc_pkg::TSC_TSEL_IN2)
            trig = sync2_r[1];
        else
            trig = sync2_r[2];
    end

    assign trig_rise = trig & ~trig_d_r;
    assign trig_fall = ~trig & trig_d_r;
    assign ext_edge = epol_r ? trig_fall : trig_rise;
    assign in1_rise = sync2_r[0] & ~in1_d_r;

    // Gated mode runs only while the gate is open; every other mode follows the enable
    assign running = (sms_r == tsc_pkg::TSC_SMS_GATED) ? cen_r & trig : cen_r; // [RULE3] [RULE13] [RULE14] [RULE22]
    assign psc_clk = (sms_r == tsc_pkg::TSC_SMS_EXT1) ? cen_r & ext_edge : running; // [RULE1] [RULE4] [RULE5]

    assign rst_trig = (sms_r == tsc_pkg::TSC_SMS_RESET) & trig_rise;
    assign psc_lim = 16'((17'h1 << psc_sh_r) - 17'h1);
    assign cnt_tick = psc_clk & (psc_cnt_r == psc_lim);
    assign ovf = cnt_tick & (cnt_r == arr_sh_r);
    assign update_event = ug_r | ovf | (rst_trig & ~urs_r); // [RULE11]
    assign uev_flag = ovf | ((ug_r | rst_trig) & ~urs_r);

    always_comb
    begin
        case (sms_r)
            tsc_pkg::TSC_SMS_EXT1: tif_set = cen_r & ext_edge; // [RULE5]
            tsc_pkg::TSC_SMS_TRIG: tif_set = trig_rise; // [RULE8]
            tsc_pkg::TSC_SMS_RESET: tif_set = trig_rise; // [RULE12]
            tsc_pkg::TSC_SMS_GATED: tif_set = cen_r & (trig_rise | trig_fall); // [RULE15]
            default: tif_set = 1'b0;
        endcase
    end

    // Control register; standard trigger mode sets the enable itself
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            cen_r <= 1'b0;
            dir_r <= 1'b0;
            urs_r <= 1'b0;
            arpe_r <= 1'b0;
        end
        else
        begin
            if (wr && paddr == tsc_pkg::TSC_CTRL_OFS)
            begin
                cen_r <= wb[tsc_pkg::TSC_CEN_BIT];
                dir_r <= wb[tsc_pkg::TSC_DIR_BIT];
                urs_r <= wb[tsc_pkg::TSC_URS_BIT];
                arpe_r <= wb[tsc_pkg::TSC_ARPE_BIT];
            end
            if (sms_r == tsc_pkg::TSC_SMS_TRIG && trig_rise)
                cen_r <= 1'b1; // [RULE7]
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            sms_r <= tsc_pkg::TSC_SMS_OFF;
            tsel_r <= tsc_pkg::TSC_TSEL_IN1;
            epol_r <= 1'b0;
            mms_r <= 1'b0;
            tie_r <= 1'b0;
            cc_in_r <= 1'b0;
        end
        else if (wr)
        begin
            if (paddr == tsc_pkg::TSC_SMODE_OFS)
            begin
                sms_r <= wb[tsc_pkg::TSC_SMS_LSB +: 3];
                tsel_r <= wb[tsc_pkg::TSC_TSEL_LSB +: 2];
                epol_r <= wb[tsc_pkg::TSC_EPOL_BIT];
                mms_r <= wb[tsc_pkg::TSC_MMS_BIT];
            end
            else if (paddr == tsc_pkg::TSC_IEN_OFS)
                tie_r <= wb[tsc_pkg::TSC_TIE_BIT];
            else if (paddr == tsc_pkg::TSC_CCMODE_OFS)
                cc_in_r <= wb[tsc_pkg::TSC_CCIN_BIT];
        end
    end

    // Flags: a hardware set wins over a software clear in the same cycle
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            tif_r <= 1'b0;
            uif_r <= 1'b0;
            ug_r <= 1'b0;
        end
        else
        begin
            if (wr && paddr == tsc_pkg::TSC_STAT_OFS)
            begin
                tif_r <= tif_r & wb[tsc_pkg::TSC_TIF_BIT];
                uif_r <= uif_r & wb[tsc_pkg::TSC_UIF_BIT];
            end
            if (tif_set)
                tif_r <= 1'b1; // [RULE5] [RULE12]
            if (uev_flag)
                uif_r <= 1'b1;
            ug_r <= wr && paddr == tsc_pkg::TSC_EVGEN_OFS && wb[tsc_pkg::TSC_UG_BIT]; // [RULE2]
        end
    end

    // Counter and prescaler
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            cnt_r <= tsc_pkg::TSC_ZERO16;
            psc_cnt_r <= tsc_pkg::TSC_ZERO16;
        end
        else if (rst_trig || ug_r)
        begin
            cnt_r <= tsc_pkg::TSC_ZERO16; // [RULE10]
            psc_cnt_r <= tsc_pkg::TSC_ZERO16;
        end
        else if (wr && paddr == tsc_pkg::TSC_CNTH_OFS)
            cnt_r[15:8] <= wb;
        else if (wr && paddr == tsc_pkg::TSC_CNTL_OFS)
            cnt_r[7:0] <= wb;
        else if (psc_clk)
        begin
            psc_cnt_r <= cnt_tick ? tsc_pkg::TSC_ZERO16 : psc_cnt_r + 16'h1;
            if (cnt_tick)
                cnt_r <= ovf ? tsc_pkg::TSC_ZERO16 : cnt_r + 16'h1;
        end
    end

    // Preload and shadow registers; high byte write locks the shadow
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            psc_pre_r <= tsc_pkg::TSC_PSC_RST;
            psc_sh_r <= tsc_pkg::TSC_PSC_RST;
            arr_pre_r <= tsc_pkg::TSC_ARR_RST;
            arr_sh_r <= tsc_pkg::TSC_ARR_RST;
            arr_lock_r <= 1'b0;
        end
        else
        begin
            if (wr && paddr == tsc_pkg::TSC_PSC_OFS)
                psc_pre_r <= wb[3:0];
            if (wr && paddr == tsc_pkg::TSC_ARRH_OFS)
            begin
                arr_pre_r[15:8] <= wb;
                arr_lock_r <= 1'b1;
            end
            else if (wr && paddr == tsc_pkg::TSC_ARRL_OFS)
            begin
                arr_pre_r[7:0] <= wb;
                arr_lock_r <= 1'b0;
                if (!arpe_r)
                    arr_sh_r <= {arr_pre_r[15:8], wb};
            end
            if (update_event)
            begin
                psc_sh_r <= psc_pre_r;
                if (!arr_lock_r)
                    arr_sh_r <= arr_pre_r;
            end
        end
    end

    // Compare/capture value; output mode writes, input mode captures
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            cc_pre_r <= tsc_pkg::TSC_ZERO16;
            cc_sh_r <= tsc_pkg::TSC_ZERO16;
            cc_lock_r <= 1'b0;
            cap_pend_r <= 1'b0;
            cc_freeze_r <= 1'b0;
        end
        else if (!cc_in_r)
        begin
            cap_pend_r <= 1'b0;
            cc_freeze_r <= 1'b0;
            if (wr && paddr == tsc_pkg::TSC_CCH_OFS)
            begin
                cc_pre_r[15:8] <= wb; // [RULE17]
                cc_lock_r <= 1'b1;
            end
            else if (wr && paddr == tsc_pkg::TSC_CCL_OFS)
            begin
                cc_pre_r[7:0] <= wb;
                cc_lock_r <= 1'b0;
            end
            if (update_event && !cc_lock_r)
                cc_sh_r <= cc_pre_r; // [RULE17]
        end
        else
        begin
            cc_lock_r <= 1'b0;
            if (rd && paddr == tsc_pkg::TSC_CCH_OFS)
                cc_freeze_r <= 1'b1; // [RULE20]
            else if (rd && paddr == tsc_pkg::TSC_CCL_OFS)
                cc_freeze_r <= 1'b0;
            if (in1_rise)
            begin
                cc_sh_r <= cnt_r; // [RULE19]
                cap_pend_r <= 1'b1;
            end
            else if (cap_pend_r && !cc_freeze_r)
            begin
                cc_pre_r <= cc_sh_r; // [RULE19] [RULE20]
                cap_pend_r <= 1'b0;
            end
        end
    end

    // Counter low byte latched when its high byte is read
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            cnt_lat_r <= 8'h00;
            cnt_lat_vld_r <= 1'b0;
        end
        else if (rd && paddr == tsc_pkg::TSC_CNTH_OFS)
        begin
            cnt_lat_r <= cnt_r[7:0]; // [RULE21]
            cnt_lat_vld_r <= 1'b1;
        end
        else if (rd && paddr == tsc_pkg::TSC_CNTL_OFS)
            cnt_lat_vld_r <= 1'b0;
    end

    // Trigger output, interrupt and compare outputs
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            trigger_output_r <= 1'b0;
            irq_r <= 1'b0;
            match_r <= 1'b0;
        end
        else
        begin
            trigger_output_r <= mms_r ? running : update_event; // [RULE16]
            irq_r <= (tif_r | tif_set) & tie_r; // [RULE5] [RULE12]
            match_r <= ~cc_in_r & cnt_tick & (cnt_r == cc_sh_r);
        end
    end

    // APB: no wait state, answer in the cycle after setup
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            pready_r <= 1'b0;
            pslverr_r <= 1'b0;
            prdata_r <= 32'h0000_0000;
        end
        else
        begin
            pready_r <= psel & ~penable & ~pready_r;
            pslverr_r <= 1'b0;
            if (psel && !penable && !pready_r)
            begin
                prdata_r <= 32'h0000_0000;
                if (paddr == tsc_pkg::TSC_CTRL_OFS)
                    prdata_r[3:0] <= {arpe_r, urs_r, dir_r, cen_r};
                else if (paddr == tsc_pkg::TSC_SMODE_OFS)
                    prdata_r[7:0] <= {mms_r, epol_r, tsel_r, 1'b0, sms_r};
                else if (paddr == tsc_pkg::TSC_IEN_OFS)
                    prdata_r[0] <= tie_r;
                else if (paddr == tsc_pkg::TSC_STAT_OFS)
                    prdata_r[1:0] <= {uif_r, tif_r};
                else if (paddr == tsc_pkg::TSC_EVGEN_OFS)
                    prdata_r[0] <= 1'b0;
                else if (paddr == tsc_pkg::TSC_CNTH_OFS)
                    prdata_r[7:0] <= cnt_r[15:8];
                else if (paddr == tsc_pkg::TSC_CNTL_OFS)
                    prdata_r[7:0] <= cnt_lat_vld_r ? cnt_lat_r : cnt_r[7:0]; // [RULE21]
                else if (paddr == tsc_pkg::TSC_PSC_OFS)
                    prdata_r[3:0] <= psc_pre_r;
                else if (paddr == tsc_pkg::TSC_ARRH_OFS)
                    prdata_r[7:0] <= arr_pre_r[15:8];
                else if (paddr == tsc_pkg::TSC_ARRL_OFS)
                    prdata_r[7:0] <= arr_pre_r[7:0];
                else if (paddr == tsc_pkg::TSC_CCH_OFS)
                    prdata_r[7:0] <= cc_pre_r[15:8]; // [RULE18]
                else if (paddr == tsc_pkg::TSC_CCL_OFS)
                    prdata_r[7:0] <= cc_pre_r[7:0];
                else if (paddr == tsc_pkg::TSC_CCMODE_OFS)
                    prdata_r[0] <= cc_in_r;
                else
                    pslverr_r <= 1'b1;
            end
        end
    end

    assign prdata = prdata_r;
    assign pready = pready_r;
    assign pslverr = pslverr_r;
    assign trigger_output = trigger_output_r;
    assign trigger_irq = irq_r;
    assign compare_match = match_r;
endmodule : tsc_top

/* File: bench/tsc_monitor.sv */
// Checker of the APB handshake and trigger outputs of the timer trigger controller
`timescale 1ns/1ps
module tsc_monitor
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic input_one,
    input wire logic input_two,
    input wire logic internal_trigger_input,
    input wire logic trigger_output,
    input wire logic trigger_irq,
    input wire logic compare_match
);
    logic mms_r;
    logic acc;
    assign acc = psel && penable && pready;
    // Output select is tracked here because the checker cannot see the register
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            mms_r <= 1'b0;
        else if (acc && pwrite && paddr == tsc_pkg::TSC_SMODE_OFS)
            mms_r <= pwdata[tsc_pkg::TSC_MMS_BIT];
    end
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);
    sequence setup_s;
        psel && !penable;
    endsequence
    sequence access_s;
        psel && penable && pready;
    endsequence
    chk_ready_after_setup: assert property (setup_s |=> access_s)
        else $error("no ready in the access cycle");
    chk_ready_one_cycle: assert property (pready |=> !pready)
        else $error("ready held longer than one cycle");
    chk_ready_in_access: assert property (pready |-> psel && penable)
        else $error("ready outside an access");
    chk_err_with_ready: assert property (pslverr |-> pready)
        else $error("error flag without ready");
    chk_err_reads_zero: assert property (pslverr && !pwrite |-> prdata == 32'h0)
        else $error("refused read returned data");
    chk_irq_mask_off: assert property ((acc && pwrite && paddr == tsc_pkg::TSC_IEN_OFS && !pwdata[0])
        |=> ##1 !trigger_irq)
        else $error("interrupt request stays after masking");
    chk_ug_trigger_output: assert property ((acc && pwrite && paddr == tsc_pkg::TSC_EVGEN_OFS && pwdata[0] && !mms_r)
        |-> ##[1:3] trigger_output)
        else $error("no update pulse after update generate");
    chk_trigger_output_pulse: assert property ((!mms_r && $stable(mms_r) && trigger_output) |=> !trigger_output)
        else $error("update pulse longer than one cycle");
endmodule : tsc_monitor

/* File: bench/tsc_pins_model.sv */
// Model of the input pins and the companion timer trigger
`timescale 1ns/1ps
module tsc_pins_model
(
    input wire logic pclk,
    output logic input_one,
    output logic input_two,
    output logic internal_trigger_input
);
    initial
    begin
        input_one = 1'b0;
        input_two = 1'b0;
        internal_trigger_input = 1'b0;
    end
    // Source 0 and 1 are the pins, 2 the companion timer trigger
    task automatic set_pin(input int sel, input logic val);
        @(posedge pclk);
        case (sel)
            0: input_one <= val;
            1: input_two <= val;
            default: internal_trigger_input <= val;
        endcase
    endtask : set_pin
    // Edges held four cycles so the two-flop synchroniser never misses one
    task automatic pulses(input int sel, input int n);
        repeat (n)
        begin
            set_pin(sel, 1'b1);
            repeat (3) @(posedge pclk);
            set_pin(sel, 1'b0);
            repeat (3) @(posedge pclk);
        end
    endtask : pulses
endmodule : tsc_pins_model

/* File: bench/tsc_top_tb.sv */
// Self-checking testbench of the timer trigger controller
`timescale 1ns/1ps
module tsc_top_tb;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic pready, pslverr, input_one, input_two, internal_trigger_input;
    logic trigger_output, trigger_irq, compare_match;
    int n_fail = 0;
    int samples_checked = 0;
    int trigger_output_cnt = 0;
    always #4 pclk = ~pclk;
    always @(posedge pclk)
        if (trigger_output === 1'b1)
            trigger_output_cnt++;
    tsc_top tsc_top_i(.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .input_one(input_one), .input_two(input_two), .internal_trigger_input(internal_trigger_input),
        .trigger_output(trigger_output), .trigger_irq(trigger_irq), .compare_match(compare_match));
    tsc_pins_model tsc_pins_model_i(.pclk(pclk), .input_one(input_one), .input_two(input_two),
        .internal_trigger_input(internal_trigger_input));
    task automatic close_out;
        if (n_fail == 0 && samples_checked > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask : close_out
    task automatic chk_val(input string nm, input logic [15:0] exp, input logic [15:0] got);
        samples_checked++;
        if (got !== exp)
        begin
            n_fail++;
            $display("FAIL %s expected %h seen %h", nm, exp, got);
        end
    endtask : chk_val
    task automatic chk_bit(input string nm, input logic exp, input logic got);
        chk_val(nm, {15'h0, exp}, {15'h0, got});
    endtask : chk_bit
    task automatic apb(input logic wr, input logic [7:0] a, input logic [7:0] d, output logic [15:0] v,
        output logic err);
        int k;
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= {24'h0, d};
        @(posedge pclk);
        penable <= 1'b1;
        k = 0;
        @(posedge pclk);
        while (pready !== 1'b1 && k < 20)
        begin
            @(posedge pclk);
            k++;
        end
        if (k == 20)
        begin
            n_fail++;
            $display("FAIL apb_ready expected 1 seen %b", pready);
            close_out();
        end
        v = {8'h00, prdata[7:0]};
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        logic [15:0] v;
        logic e;
        apb(1'b1, a, d, v, e);
    endtask : wr
    task automatic rd(input logic [7:0] a, output logic [15:0] v);
        logic e;
        apb(1'b0, a, 8'h00, v, e);
    endtask : rd
    task automatic rd16(input logic [7:0] a, output logic [15:0] v);
        logic [15:0] h;
        logic [15:0] l;
        rd(a, h);
        rd(a + 8'h04, l);
        v = {h[7:0], l[7:0]};
    endtask : rd16
    task automatic s_regs;
        logic [15:0] v;
        logic e;
        rd16(8'h20, v);
        chk_val("arr_reset", 16'hffff, v);
        apb(1'b0, 8'h3c, 8'h00, v, e);
        chk_bit("unmapped_err", 1'b1, e);
        chk_val("unmapped_data", 16'h0000, v);
    endtask : s_regs
    task automatic s_internal;
        logic [15:0] v, w;
        wr(8'h04, 8'h00);
        wr(8'h10, 8'h01);
        wr(8'h00, 8'h01);
        repeat (20) @(posedge pclk);
        rd16(8'h14, v);
        chk_bit("internal_runs", 1'b1, v > 16'h0010);
        wr(8'h00, 8'h00);
        rd16(8'h14, v);
        repeat (10) @(posedge pclk);
        rd16(8'h14, w);
        chk_val("sw_stop", v, w);
        wr(8'h00, 8'h01);
        wr(8'h10, 8'h01);
        rd16(8'h14, v);
        chk_bit("ug_clear", 1'b1, v != 16'h0000 && v < 16'h0010);
        wr(8'h00, 8'h00);
    endtask : s_internal
    task automatic s_ext;
        logic [15:0] v;
        wr(8'h14, 8'h00);
        wr(8'h18, 8'h00);
        wr(8'h0c, 8'h00);
        wr(8'h08, 8'h01);
        wr(8'h04, 8'h07);
        wr(8'h00, 8'h01);
        tsc_pins_model_i.pulses(0, 5);
        repeat (4) @(posedge pclk);
        rd16(8'h14, v);
        chk_val("edge_count", 16'h0005, v);
        rd(8'h0c, v);
        chk_bit("ext_flag", 1'b1, v[0]);
        chk_bit("ext_irq", 1'b1, trigger_irq);
        wr(8'h08, 8'h00);
        repeat (3) @(posedge pclk);
        chk_bit("irq_masked", 1'b0, trigger_irq);
    endtask : s_ext
    task automatic s_trig;
        logic [15:0] v, w;
        wr(8'h00, 8'h00);
        wr(8'h04, 8'h26);
        wr(8'h14, 8'h00);
        wr(8'h18, 8'h00);
        wr(8'h0c, 8'h00);
        repeat (8) @(posedge pclk);
        rd16(8'h14, v);
        chk_val("wait_trigger", 16'h0000, v);
        tsc_pins_model_i.set_pin(2, 1'b1);
        repeat (10) @(posedge pclk);
        rd(8'h00, v);
        chk_val("hw_enable", 16'h0001, v);
        rd16(8'h14, v);
        repeat (10) @(posedge pclk);
        rd16(8'h14, w);
        chk_bit("keeps_running", 1'b1, w > v);
        rd(8'h0c, v);
        chk_bit("trig_flag", 1'b1, v[0]);
        tsc_pins_model_i.set_pin(2, 1'b0);
        wr(8'h00, 8'h00);
    endtask : s_trig
    task automatic s_reset;
        logic [15:0] v;
        int n;
        wr(8'h04, 8'h14);
        wr(8'h14, 8'h00);
        wr(8'h18, 8'h00);
        wr(8'h20, 8'h00);
        wr(8'h24, 8'h80);
        wr(8'h0c, 8'h00);
        wr(8'h00, 8'h01);
        repeat (30) @(posedge pclk);
        n = trigger_output_cnt;
        tsc_pins_model_i.set_pin(1, 1'b1);
        repeat (6) @(posedge pclk);
        chk_bit("reset_uev", 1'b1, trigger_output_cnt > n);
        rd16(8'h14, v);
        chk_bit("count_restart", 1'b1, v < 16'h0010);
        rd(8'h0c, v);
        chk_bit("reset_flag", 1'b1, v[0]);
        tsc_pins_model_i.set_pin(1, 1'b0);
        wr(8'h00, 8'h05);
        repeat (3) @(posedge pclk);
        n = trigger_output_cnt;
        tsc_pins_model_i.set_pin(1, 1'b1);
        repeat (6) @(posedge pclk);
        chk_bit("urs_no_uev", 1'b0, trigger_output_cnt > n);
        tsc_pins_model_i.set_pin(1, 1'b0);
        wr(8'h00, 8'h00);
    endtask : s_reset
    task automatic s_gated;
        logic [15:0] v, w;
        wr(8'h04, 8'h85);
        wr(8'h0c, 8'h00);
        wr(8'h00, 8'h01);
        rd16(8'h14, v);
        repeat (5) @(posedge pclk);
        rd16(8'h14, w);
        chk_val("gate_low", v, w);
        tsc_pins_model_i.set_pin(0, 1'b1);
        repeat (10) @(posedge pclk);
        rd16(8'h14, w);
        chk_bit("gate_high", 1'b1, w > v);
        chk_bit("trigger_output_level", 1'b1, trigger_output);
        rd(8'h0c, v);
        chk_bit("start_flag", 1'b1, v[0]);
        wr(8'h0c, 8'h00);
        tsc_pins_model_i.set_pin(0, 1'b0);
        repeat (6) @(posedge pclk);
        rd(8'h0c, v);
        chk_bit("stop_flag", 1'b1, v[0]);
        rd16(8'h14, v);
        repeat (5) @(posedge pclk);
        rd16(8'h14, w);
        chk_val("gate_stopped", v, w);
        chk_bit("trigger_output_idle", 1'b0, trigger_output);
        wr(8'h00, 8'h00);
        tsc_pins_model_i.set_pin(0, 1'b1);
        repeat (6) @(posedge pclk);
        rd16(8'h14, v);
        repeat (5) @(posedge pclk);
        rd16(8'h14, w);
        chk_val("gate_disabled", v, w);
        tsc_pins_model_i.set_pin(0, 1'b0);
    endtask : s_gated
    task automatic s_ccr;
        logic [15:0] v;
        int k;
        wr(8'h04, 8'h00);
        wr(8'h28, 8'hab);
        wr(8'h2c, 8'hcd);
        rd16(8'h28, v);
        chk_val("cc_preload", 16'habcd, v);
        wr(8'h28, 8'h00);
        wr(8'h2c, 8'h40);
        wr(8'h10, 8'h01);
        wr(8'h00, 8'h01);
        k = 0;
        while (compare_match !== 1'b1 && k < 100)
        begin
            @(posedge pclk);
            k++;
        end
        chk_bit("compare_match", 1'b1, compare_match);
        if (k == 100)
            close_out();
        @(posedge pclk);
        chk_bit("match_pulse", 1'b0, compare_match);
        wr(8'h00, 8'h00);
        wr(8'h30, 8'h01);
        wr(8'h14, 8'h12);
        wr(8'h18, 8'h34);
        tsc_pins_model_i.pulses(0, 1);
        rd16(8'h28, v);
        chk_val("capture", 16'h1234, v);
        wr(8'h14, 8'h56);
        wr(8'h18, 8'h78);
        rd(8'h28, v);
        chk_val("cap_high", 16'h0012, v);
        tsc_pins_model_i.pulses(0, 1);
        rd(8'h2c, v);
        chk_val("cap_frozen", 16'h0034, v);
        repeat (3) @(posedge pclk);
        rd16(8'h28, v);
        chk_val("cap_after", 16'h5678, v);
        wr(8'h28, 8'haa);
        rd(8'h28, v);
        chk_val("cap_readonly", 16'h0056, v);
    endtask : s_ccr
    initial
    begin
        repeat (5) @(posedge pclk);
        presetn <= 1'b1;
        s_regs();
        s_internal();
        s_ext();
        s_trig();
        s_reset();
        s_gated();
        s_ccr();
        close_out();
    end
endmodule : tsc_top_tb
bind tsc_top tsc_monitor tsc_monitor_i(.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .input_one(input_one), .input_two(input_two), .internal_trigger_input(internal_trigger_input),
    .trigger_output(trigger_output), .trigger_irq(trigger_irq), .compare_match(compare_match));
